// ==== bench/accum_memop_mem_model.sv ====
// Behavioural memory answering the datapath after a set wait.
// Assumes the bench preloads and inspects words through the mem array.
`timescale 1ns/1ps
module accum_memop_mem_model (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic MEM_REQ,
   input wire accum_memop_pkg::mem_cmd_t MEM_CMD,
   input wire logic [3:0] DELAY,
   output logic MEM_ACK,
   output logic [15:0] MEM_RDATA
);
   import accum_memop_pkg::*;
   logic [15:0] mem [0:255];
   logic [3:0] waited;
   logic [15:0] junk;
   // ------------------------------------------------
   // Answer
   // ------------------------------------------------
   // Acknowledge once the request has waited DELAY cycles
   assign MEM_ACK = MEM_REQ && (waited == DELAY);
   // Read word only with the answer, a toggling pattern otherwise
   assign MEM_RDATA = MEM_ACK ? mem[MEM_CMD.addr[7:0]] : junk;
   // Wait counter, junk pattern and write port
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         waited <= 4'h0;
         junk <= 16'hA5C3;
      end else begin
         junk <= ~junk;
         waited <= (MEM_REQ && !MEM_ACK) ? waited + 4'h1 : 4'h0;
         if (MEM_ACK && MEM_CMD.write) begin
            mem[MEM_CMD.addr[7:0]] <= MEM_CMD.wdata;
         end
      end
   end
endmodule

// ==== bench/accum_memop_monitor.sv ====
// Concurrent checks on the memory-reference datapath ports.
// Assumes a bind to the top module: one clock, async active-low reset.
`timescale 1ns/1ps
module accum_memop_monitor
   import accum_memop_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic START,
   input wire logic [15:0] INSTR,
   input wire logic COUPLER_SEL,
   input wire logic MEM_REQ,
   input wire accum_memop_pkg::mem_cmd_t MEM_CMD,
   input wire logic BUSY,
   input wire logic DONE,
   input wire accum_memop_pkg::cycle_t CYCLE,
   input wire logic [15:0] ACCUM,
   input wire logic END_CARRY
);
   // ------------------------------------------------
   // Helper state
   // ------------------------------------------------
   opgroup_t grp;
   logic [15:0] rd_addr;
   wire logic taken = START && !BUSY && INSTR[15:11] >= 5'h0C && INSTR[15:11] <= 5'h16;
   wire logic wr_zero = grp == OP_STZERO || grp == OP_DLOAD;
   wire logic rmw = (grp >= OP_RADD && grp <= OP_RRBYTE) || grp == OP_DLOAD;
   wire logic arith = grp == OP_ADD || grp == OP_SUB || grp == OP_RADD || grp == OP_RADD1;
   // Remember the running group and the address of the last read
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         grp <= OP_ADD;
         rd_addr <= 16'h0000;
      end else begin
         if (taken) begin
            grp <= opgroup_t'(INSTR[15:11]);
         end
         if (MEM_REQ && !MEM_CMD.write) begin
            rd_addr <= MEM_CMD.addr;
         end
      end
   end
   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   sequence s_taken;
      taken;
   endsequence
   sequence s_write_req;
      MEM_REQ && MEM_CMD.write;
   endsequence
   a_busy_tracks_cycle: assert property (BUSY == (CYCLE != next_instruction_cycle))
      else $error("busy disagrees with cycle");
   a_start_enters_cycle: assert property (s_taken |=>
      CYCLE == (($past(INSTR[15:12]) == 4'hA) ? memory_write_cycle : operand_read_cycle))
      else $error("wrong first cycle");
   a_done_bounded: assert property ($rose(BUSY) |-> ##[9:60] DONE)
      else $error("no completion in time");
   a_write_in_store: assert property (MEM_REQ |-> MEM_CMD.write == (CYCLE == memory_write_cycle))
      else $error("write flag outside store cycle");
   a_addr_kept_rmw: assert property ((s_write_req and rmw) |-> MEM_CMD.addr == rd_addr)
      else $error("store address differs from read");
   a_zero_write_data: assert property ((s_write_req and wr_zero) |-> MEM_CMD.wdata == WORD_ZERO)
      else $error("zero write carries data");
   a_accum_write_data: assert property ((s_write_req and (!wr_zero && !COUPLER_SEL)) |->
      MEM_CMD.wdata == ACCUM)
      else $error("write data is not the accumulator");
   a_accum_held_store: assert property ((CYCLE == memory_write_cycle) [*2] |-> $stable(ACCUM))
      else $error("accumulator moved in store cycle");
   a_carry_scope: assert property ($changed(END_CARRY) |-> arith)
      else $error("end carry changed by non-arithmetic op");
endmodule

// ==== bench/accumulator_memory_op_datapath_tb_top.sv ====
// Self-checking bench for the memory-reference datapath.
// Assumes the memory model answers every request; inputs move 1 ns after edges.
`timescale 1ns/1ps
module accumulator_memory_op_datapath_tb_top;
   import accum_memop_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic csel = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [15:0] ea = 16'h0000;
   logic [15:0] cword = 16'hC3A5;
   logic [3:0] dly = 4'h0;
   logic ack, req, busy, done, carry;
   logic [15:0] rdata, acc;
   mem_cmd_t cmd;
   cycle_t cyc;
   int bad_count = 0;
   int num_checks = 0;
   // ------------------------------------------------
   // Clock, design and memory
   // ------------------------------------------------
   always #4 clk = ~clk;
   accumulator_memory_op_datapath i_dut (.CLOCK(clk), .RSTN(rstn), .START(start), .INSTR(instr),
      .EXEC_ADDR(ea), .MEM_ACK(ack), .MEM_RDATA(rdata), .COUPLER_SEL(csel), .COUPLER_WORD(cword),
      .MEM_REQ(req), .MEM_CMD(cmd), .BUSY(busy), .DONE(done), .CYCLE(cyc), .ACCUM(acc), .END_CARRY(carry));
   accum_memop_mem_model i_mem (.CLOCK(clk), .RSTN(rstn), .MEM_REQ(req), .MEM_CMD(cmd), .DELAY(dly),
      .MEM_ACK(ack), .MEM_RDATA(rdata));
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask
   // Preload the word, issue one instruction and wait for completion
   task automatic do_op(input logic [15:0] ins, input logic [15:0] a, input logic [15:0] w,
      input logic [3:0] d);
      int n;
      i_mem.mem[a[7:0]] = w;
      dly = d;
      instr = ins;
      ea = a;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 100) begin
         bad_count++;
         $display("MISMATCH t=%0t no completion", $time);
         wrap_up();
      end
      chk_flag(busy, 1'b0);
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_arith();
      do_op(16'hB012, 16'h0005, 16'h8001, 4'h0);
      chk_word(acc, 16'h8001);
      chk_word(i_mem.mem[5], WORD_ZERO);
      do_op(16'h6034, 16'h0006, 16'h9000, 4'h2);
      chk_word(acc, 16'h1001);
      chk_flag(carry, 1'b1);
      do_op(16'h6F00, 16'h0006, 16'h1002, 4'h1);
      chk_word(acc, 16'hFFFF);
      chk_flag(carry, 1'b0);
      $display("arith test ended");
   endtask
   task automatic t_logic();
      do_op(16'h7011, 16'h0020, 16'h0F0F, 4'h0);
      chk_word(acc, 16'hF0F0);
      do_op(16'h7FEE, 16'h0021, 16'h3C3C, 4'h3);
      chk_word(acc, 16'h3030);
      $display("logic test ended");
   endtask
   task automatic t_rmw();
      do_op(16'h8877, 16'h0008, 16'h12FF, 4'h2);
      chk_word(acc, 16'h1300);
      chk_word(i_mem.mem[8], 16'h1300);
      do_op(16'h8000, 16'h0007, 16'hFFFF, 4'h3);
      chk_word(acc, 16'h12FF);
      chk_flag(carry, 1'b1);
      chk_word(i_mem.mem[7], 16'h12FF);
      do_op(16'h9055, 16'h0009, 16'hAB34, 4'h0);
      chk_word(acc, 16'hFF34);
      chk_word(i_mem.mem[9], 16'hFF34);
      do_op(16'h9F00, 16'h000A, 16'h5678, 4'h1);
      chk_word(acc, 16'h5634);
      chk_word(i_mem.mem[10], 16'h5634);
      $display("replace test ended");
   endtask
   task automatic t_store();
      do_op(16'hA000, 16'h000B, 16'h1111, 4'h1);
      chk_word(i_mem.mem[11], 16'h5634);
      chk_word(acc, 16'h5634);
      csel = 1'b1;
      do_op(16'hA7FF, 16'h000C, 16'h2222, 4'h0);
      chk_word(i_mem.mem[12], 16'hC3A5);
      do_op(16'hA800, 16'h000D, 16'h7777, 4'h2);
      chk_word(i_mem.mem[13], WORD_ZERO);
      csel = 1'b0;
      $display("store test ended");
   endtask
   task automatic t_refuse();
      instr = 16'h4000;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk_flag(busy, 1'b0);
      chk_word(acc, 16'h5634);
      $display("refuse test ended");
   endtask
   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1 chk_word(acc, WORD_ZERO);
      t_arith();
      t_logic();
      t_rmw();
      t_store();
      t_refuse();
      wrap_up();
   end
endmodule
bind accumulator_memory_op_datapath accum_memop_monitor i_mon (.CLOCK(CLOCK), .RSTN(RSTN), .START(START),
   .INSTR(INSTR), .COUPLER_SEL(COUPLER_SEL), .MEM_REQ(MEM_REQ), .MEM_CMD(MEM_CMD), .BUSY(BUSY),
   .DONE(DONE), .CYCLE(CYCLE), .ACCUM(ACCUM), .END_CARRY(END_CARRY));

// ==== logic/accum_memop_alu.sv ====
// Shared adder, logic unit and byte shift network feeding the result bus.
// Assumes gate controls are decoded by the sequencer and stable for the whole cycle.
`timescale 1ns/1ps
module accum_memop_alu (
   input wire logic [15:0] ACCUM,
   input wire logic [15:0] OPERAND,
   input wire accum_memop_pkg::gate_ctl_t CTL,
   output logic [15:0] RESULT,
   output logic CARRY_OUT
);
   import accum_memop_pkg::*;

   wire [15:0] in_a;
   wire [15:0] in_b_raw;
   wire [15:0] in_b;
   wire [16:0] sum;
   wire [15:0] logic_bus;
   wire [15:0] shifted;
   wire [15:0] shift_bus;

   // ------------------------------------------------------------
   // Adder inputs
   // ------------------------------------------------------------
   // Accumulator gate onto the first input
   assign in_a = CTL.accum_to_adder_gate ? ACCUM : WORD_ZERO;
   // Byte gates zero-fill whichever half is not passed
   assign in_b_raw = {CTL.operand_high_byte_gate ? OPERAND[15:8] : BYTE_ZERO,
                      CTL.operand_low_byte_gate ? OPERAND[7:0] : BYTE_ZERO};
   // Ones complement for subtract, completed by forced carry
   assign in_b = CTL.operand_invert_gate ? ~OPERAND : in_b_raw;
   // Sum wraps at 16 bits, bit 16 is the end carry
   assign sum = {1'b0, in_a} + {1'b0, in_b} + {16'h0000, CTL.adder_carry_in};
   assign CARRY_OUT = sum[16];

   // ------------------------------------------------------------
   // Result bus selection and shift network
   // ------------------------------------------------------------
   // One of sum, xor or and drives the first result path
   assign logic_bus = CTL.sum_result_select ? sum[15:0] :
                      CTL.xor_result_select ? (in_a ^ in_b) :
                      CTL.and_result_select ? (in_a & in_b) : WORD_ZERO;
   // Right eight, end-around in rotate mode, else zero-filled
   assign shifted = !CTL.shift_right_eight_cmd ? ACCUM :
                    CTL.rotate_mode_ctl ? {ACCUM[7:0], ACCUM[15:8]} : {BYTE_ZERO, ACCUM[15:8]};
   // Half selects merge shifter bytes with the adder byte
   assign shift_bus = {CTL.shifter_high_half_select ? shifted[15:8] : BYTE_ZERO,
                       CTL.shifter_low_half_select ? shifted[7:0] : BYTE_ZERO};
   assign RESULT = logic_bus | shift_bus;

endmodule

// ==== logic/accum_memop_pkg.sv ====
// Constants, opcode groups and carrier types for the memory-reference execution datapath.
// Assumes a 16-bit word machine whose opcode group sits in instruction bits 15..11.
package accum_memop_pkg;

   // ----------------------------------------------------------------
   // Word and opcode layout
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 11;
   localparam int OPC_W = OPC_HI - OPC_LO + 1;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Opcode groups, each one covers eight consecutive high-byte codes
   typedef enum logic [4:0] {
      OP_ADD = 5'h0C,           // 60XX..67XX
      OP_SUB = 5'h0D,           // 68XX..6FXX
      OP_XOR = 5'h0E,           // 70XX..77XX
      OP_AND = 5'h0F,           // 78XX..7FXX
      OP_RADD = 5'h10,          // 80XX..87XX
      OP_RADD1 = 5'h11,         // 88XX..8FXX
      OP_RLBYTE = 5'h12,        // 90XX..97XX
      OP_RRBYTE = 5'h13,        // 98XX..9FXX
      OP_STORE = 5'h14,         // A0XX..A7XX
      OP_STZERO = 5'h15,        // A8XX..AFXX
      OP_DLOAD = 5'h16          // B0XX..B7XX
   } opgroup_t;

   // ----------------------------------------------------------------
   // Major cycles and timing chain
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      next_instruction_cycle = 2'b00,
      operand_read_cycle = 2'b01,
      memory_write_cycle = 2'b10
   } cycle_t;

   localparam int STEP_W = 4;
   localparam logic [3:0] STEP_T00 = 4'h0;
   localparam logic [3:0] STEP_T01 = 4'h1;
   localparam logic [3:0] STEP_MEM = 4'h2;
   localparam logic [3:0] STEP_T09 = 4'h9;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic accum_to_adder_gate;
      logic operand_high_byte_gate;
      logic operand_low_byte_gate;
      logic operand_invert_gate;
      logic adder_carry_in;
      logic sum_result_select;
      logic xor_result_select;
      logic and_result_select;
      logic shift_right_eight_cmd;
      logic rotate_mode_ctl;
      logic shifter_high_half_select;
      logic shifter_low_half_select;
   } gate_ctl_t;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_cmd_t;

endpackage

// ==== logic/accumulator_memory_op_datapath.sv ====
// Execution datapath for memory-reference instructions 60XX..B7XX.
// Assumes the execution address is already formed when START is raised, and that
// memory answers a request held on MEM_REQ with a one-cycle MEM_ACK.
`timescale 1ns/1ps

// Contract
// - Add operand to accumulator, load at T00
// - Subtract via inverted operand plus forced carry
// - Arithmetic ops clock end carry at T00
// - XOR result loads accumulator at T00
// - AND result loads accumulator at T00
// - Replace add stores sum back to memory
// - Read-modify-write ops enter a store cycle
// - Store after read keeps memory address
// - Replace add one stores operand plus one
// - Left byte: accum low high, operand low
// - Right byte: operand high, accum low kept
// - Ungated operand byte is zero-filled
// - Store writes accumulator, accumulator unchanged
// - Store zeros writes all-zero word
// - Destructive load takes operand, writes zero
// - Unselected coupler path sends accumulator out
module accumulator_memory_op_datapath (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic START,
   input wire logic [15:0] INSTR,
   input wire logic [15:0] EXEC_ADDR,
   input wire logic MEM_ACK,
   input wire logic [15:0] MEM_RDATA,
   input wire logic COUPLER_SEL,
   input wire logic [15:0] COUPLER_WORD,
   output logic MEM_REQ,
   output accum_memop_pkg::mem_cmd_t MEM_CMD,
   output logic BUSY,
   output logic DONE,
   output accum_memop_pkg::cycle_t CYCLE,
   output logic [15:0] ACCUM,
   output logic END_CARRY
);
   import accum_memop_pkg::*;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Groups that pass through a store cycle after reading
   function automatic logic is_rmw(input logic [4:0] g);
      is_rmw = (g == OP_RADD) || (g == OP_RADD1) || (g == OP_RLBYTE) ||
               (g == OP_RRBYTE) || (g == OP_DLOAD);
   endfunction

   // Groups that skip the operand read
   function automatic logic is_store_only(input logic [4:0] g);
      is_store_only = (g == OP_STORE) || (g == OP_STZERO);
   endfunction

   // Groups whose result reaches the adder end carry
   function automatic logic is_arith(input logic [4:0] g);
      is_arith = (g == OP_ADD) || (g == OP_SUB) || (g == OP_RADD) || (g == OP_RADD1);
   endfunction

   cycle_t cycle;
   logic [3:0] step;
   logic [4:0] opgroup;
   logic [15:0] operand;
   logic [15:0] mem_addr;
   logic [15:0] wdata;
   logic mem_write;
   logic done;
   logic end_carry;
   logic [15:0] accum;

   wire [4:0] start_group;
   wire start_known;
   wire start_ok;
   wire idle;
   wire at_mem;
   wire at_t00;
   wire step_hold;
   wire [3:0] next_step;
   wire read_modify_write_decode;
   wire accum_load_strobe;
   wire mem_address_load_strobe;
   wire zero_write_select;
   wire coupler_word_to_write_bus;
   wire carry_strobe;
   wire rop_end;
   wire sto_end;
   wire [15:0] write_bus;
   wire [15:0] result;
   wire alu_carry;
   // Net, so each gate field may have its own continuous driver
   wire gate_ctl_t ctl;

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   // Only groups 60..B7 are taken, others are ignored
   assign start_group = INSTR[OPC_HI:OPC_LO];
   assign start_known = (start_group >= OP_ADD) && (start_group <= OP_DLOAD);
   assign idle = (cycle == next_instruction_cycle);
   assign start_ok = START && idle && start_known;
   // Address is loaded only when a new instruction starts
   assign mem_address_load_strobe = start_ok;

   // ------------------------------------------------------------
   // Timing chain
   // ------------------------------------------------------------
   // Chain stops at the memory step until memory answers
   assign at_mem = !idle && (step == STEP_MEM);
   assign at_t00 = !idle && (step == STEP_T00);
   assign step_hold = at_mem && !MEM_ACK;
   assign next_step = (step == STEP_T09) ? STEP_T00 : step + 4'h1;
   assign rop_end = at_t00 && (cycle == operand_read_cycle);
   assign sto_end = at_t00 && (cycle == memory_write_cycle);
   assign read_modify_write_decode = is_rmw(opgroup);

   // ------------------------------------------------------------
   // Gate controls for the adder and shift network
   // ------------------------------------------------------------
   // Full operand for add, sub-free ops and destructive load
   assign ctl.operand_high_byte_gate = (opgroup != OP_RLBYTE);
   // Only the low byte for replace leftmost byte
   assign ctl.operand_low_byte_gate = (opgroup != OP_RRBYTE);
   assign ctl.operand_invert_gate = (opgroup == OP_SUB);
   // Forced carry for subtract and increment
   assign ctl.adder_carry_in = (opgroup == OP_SUB) || (opgroup == OP_RADD1);
   assign ctl.accum_to_adder_gate = (opgroup == OP_ADD) || (opgroup == OP_SUB) ||
                                    (opgroup == OP_XOR) || (opgroup == OP_AND) ||
                                    (opgroup == OP_RADD);
   assign ctl.xor_result_select = (opgroup == OP_XOR);
   assign ctl.and_result_select = (opgroup == OP_AND);
   assign ctl.sum_result_select = !ctl.xor_result_select && !ctl.and_result_select;
   // End-around right eight of the accumulator
   assign ctl.shift_right_eight_cmd = (opgroup == OP_RLBYTE);
   assign ctl.rotate_mode_ctl = (opgroup == OP_RLBYTE);
   assign ctl.shifter_high_half_select = (opgroup == OP_RLBYTE);
   assign ctl.shifter_low_half_select = (opgroup == OP_RRBYTE);

   accum_memop_alu u_alu (
      .ACCUM(accum),
      .OPERAND(operand),
      .CTL(ctl),
      .RESULT(result),
      .CARRY_OUT(alu_carry)
   );

   // ------------------------------------------------------------
   // Strobes at T00 and memory write path
   // ------------------------------------------------------------
   // Every read group loads the accumulator at the end of its read
   assign accum_load_strobe = rop_end;
   assign carry_strobe = rop_end && is_arith(opgroup);
   // Zero word for store zeros and destructive load
   assign zero_write_select = (opgroup == OP_STZERO) || (opgroup == OP_DLOAD);
   assign coupler_word_to_write_bus = COUPLER_SEL;
   // Accumulator reaches memory unless zero or coupler is chosen
   assign write_bus = zero_write_select ? WORD_ZERO :
                      coupler_word_to_write_bus ? COUPLER_WORD : accum;

   // Major cycle sequencer
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cycle <= next_instruction_cycle;
         step <= STEP_T00;
      end else if (start_ok) begin
         // Store groups go straight to the store cycle
         cycle <= is_store_only(start_group) ? memory_write_cycle : operand_read_cycle;
         step <= STEP_T01;
      end else if (!idle && !step_hold) begin
         step <= next_step;
         unique case (cycle)
            operand_read_cycle: begin
               // Read-modify-write enters a store instead of ending
               if (at_t00) begin
                  cycle <= read_modify_write_decode ? memory_write_cycle : next_instruction_cycle;
                  step <= read_modify_write_decode ? STEP_T01 : STEP_T00;
               end
            end
            memory_write_cycle: begin
               if (at_t00) begin
                  cycle <= next_instruction_cycle;
               end
            end
            next_instruction_cycle: begin
               step <= STEP_T00;
            end
            default: begin
               cycle <= next_instruction_cycle;
               step <= STEP_T00;
            end
         endcase
      end
   end

   // Instruction group and execution address hold
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         opgroup <= OP_ADD;
         mem_addr <= WORD_ZERO;
      end else if (mem_address_load_strobe) begin
         opgroup <= start_group;
         mem_addr <= EXEC_ADDR;
      end
   end

   // Operand capture from memory
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         operand <= WORD_ZERO;
      end else if (at_mem && MEM_ACK && (cycle == operand_read_cycle)) begin
         operand <= MEM_RDATA;
      end
   end

   // Accumulator and end carry, both clocked at T00 of the read
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         accum <= WORD_ZERO;
         end_carry <= 1'b0;
      end else begin
         if (accum_load_strobe) begin
            accum <= result;
         end
         if (carry_strobe) begin
            end_carry <= alu_carry;
         end
      end
   end

   // Write word and direction captured at T01 of every read or store cycle
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         wdata <= WORD_ZERO;
         mem_write <= 1'b0;
      end else if (!idle && (step == STEP_T01)) begin
         wdata <= write_bus;
         mem_write <= (cycle == memory_write_cycle);
      end
   end

   // Completion pulse as control returns to the next instruction
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         done <= 1'b0;
      end else begin
         done <= (rop_end && !read_modify_write_decode) || sto_end;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign MEM_REQ = at_mem;
   // One driver for the whole command word, direction in the top bit
   assign MEM_CMD = mem_cmd_t'({mem_write, mem_addr, wdata});
   assign BUSY = !idle;
   assign DONE = done;
   assign CYCLE = cycle;
   assign ACCUM = accum;
   assign END_CARRY = end_carry;

endmodule
